// File: common/drive_monitor_params.svh
// Object indices, field positions, reset values and timing for the drive monitor
`ifndef DRIVE_MONITOR_PARAMS_SVH
`define DRIVE_MONITOR_PARAMS_SVH

// Object dictionary indices
`define IDX_COMMAND_WORD    16'h6040
`define IDX_STATE_REPORT    16'h6041
`define IDX_RAPID_HALT      16'h605A
`define IDX_POWER_DOWN      16'h605B
`define IDX_RUN_STOP        16'h605C
`define IDX_PAUSE           16'h605D
`define IDX_ERROR_RESPONSE  16'h605E
`define IDX_COMMANDED_LOC   16'h6062
`define IDX_MEASURED_RAW    16'h6063
`define IDX_MEASURED_LOC    16'h6064
`define IDX_LAG_TOLERANCE   16'h6065
`define IDX_LAG_GRACE       16'h6066
`define IDX_ARRIVAL_TOL     16'h6067
`define IDX_ARRIVAL_DWELL   16'h6068
`define IDX_LOOP_OUTPUT     16'h60FA

// Reset values and the lag tolerance limit
`define RST_COMMAND_WORD    16'h0000
`define RST_OPTION_CODE     16'h0000
`define RST_LAG_TOLERANCE   32'h0000_7530
`define RST_LAG_GRACE       16'h00C8
`define RST_ARRIVAL_TOL     32'h0000_000A
`define RST_ARRIVAL_DWELL   16'h0032
`define LAG_TOLERANCE_MAX   32'h7FFF_FFFF

// Command word bits
`define CMD_SWITCH_ON       0
`define CMD_ENABLE_VOLTAGE  1
`define CMD_QUICK_STOP_N    2
`define CMD_ENABLE_OP       3
`define CMD_FAULT_RESET     7
`define CMD_HALT            8

// State report bits
`define RPT_READY           0
`define RPT_SWITCHED_ON     1
`define RPT_OP_ENABLED      2
`define RPT_FAULT           3
`define RPT_VOLTAGE         4
`define RPT_QUICK_STOP      5
`define RPT_SW_ON_DISABLED  6
`define RPT_WARNING         7
`define RPT_REMOTE          9
`define RPT_ARRIVED         10
`define RPT_LAG_FAULT       13

// Time base
`define CLK_PERIOD_NS       10
`define MS_TIME_NS          1000000
`define MS_TICK_CYCLES      (`MS_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: common/drive_monitor_pkg.sv
// Types shared by the drive monitor
`default_nettype none
package drive_monitor_pkg;

  // Power-stage states
  typedef enum logic [2:0] {
    st_not_ready   = 3'b000,
    st_sw_disabled = 3'b001,
    st_ready       = 3'b010,
    st_switched_on = 3'b011,
    st_op_enabled  = 3'b100,
    st_quick_stop  = 3'b101,
    st_fault_react = 3'b110,
    st_fault       = 3'b111
  } drive_state_t;

endpackage
`default_nettype wire

// File: rtl/drive_monitor.sv
// Position supervision and power-stage state control of a servo drive
`timescale 1ns/10ps
`default_nettype none
`include "drive_monitor_params.svh"

module drive_monitor #(
  parameter int unsigned TICK_CYCLES = `MS_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Object dictionary access
  input  wire logic        od_valid,
  input  wire logic        od_write,
  input  wire logic [15:0] od_index,
  input  wire logic [31:0] od_wdata,
  output logic             od_ready,
  output logic             od_error,
  output logic      [31:0] od_rdata,
  // Position inputs from trajectory and encoder, and the loop output
  input  wire logic [31:0] commanded_pos,
  input  wire logic [31:0] measured_pos,
  input  wire logic [31:0] measured_raw_pos,
  input  wire logic [31:0] goal_pos,
  input  wire logic [31:0] loop_effort,
  // Drive condition inputs
  input  wire logic        self_test_done,
  input  wire logic        alarm,
  input  wire logic        motor_stopped,
  // Power stage and report outputs
  output logic             main_power_on,
  output logic             motor_excited,
  output logic             halt_request,
  output logic             lag_fault,
  output logic             arrival,
  output logic      [15:0] state_report
);

  drive_monitor_pkg::drive_state_t state;
  drive_monitor_pkg::drive_state_t next_state;

  logic [15:0] command_word;
  logic [15:0] rapid_halt_behaviour;
  logic [15:0] power_down_behaviour;
  logic [15:0] run_stop_behaviour;
  logic [15:0] pause_behaviour;
  logic [15:0] error_response_behaviour;
  logic [31:0] lag_tolerance;
  logic [15:0] lag_grace_period;
  logic [31:0] arrival_tolerance;
  logic [15:0] arrival_dwell;
  logic        prev_fault_reset;
  logic [31:0] tick_count;
  logic        ms_tick;
  logic [15:0] lag_count;
  logic [15:0] dwell_count;
  logic [32:0] lag_error;
  logic [32:0] lag_mag;
  logic [32:0] goal_error;
  logic [32:0] goal_mag;
  logic        lag_outside;
  logic        arr_inside;
  logic        fault_reset_edge;

  // Command decodes used by several transitions
  function automatic logic is_shutdown(input logic [15:0] c);
    return c[`CMD_QUICK_STOP_N] & c[`CMD_ENABLE_VOLTAGE] & ~c[`CMD_SWITCH_ON];
  endfunction

  function automatic logic is_switch_on(input logic [15:0] c);
    return c[`CMD_QUICK_STOP_N] & c[`CMD_ENABLE_VOLTAGE] & c[`CMD_SWITCH_ON]
           & ~c[`CMD_ENABLE_OP];
  endfunction

  function automatic logic is_enable_op(input logic [15:0] c);
    return c[`CMD_QUICK_STOP_N] & c[`CMD_ENABLE_VOLTAGE] & c[`CMD_SWITCH_ON]
           & c[`CMD_ENABLE_OP];
  endfunction

  function automatic logic is_quick_stop(input logic [15:0] c);
    return c[`CMD_ENABLE_VOLTAGE] & ~c[`CMD_QUICK_STOP_N];
  endfunction

  // Main power on in every state of the power-enabled group
  function automatic logic power_of(input drive_monitor_pkg::drive_state_t s);
    return (s == drive_monitor_pkg::st_switched_on) || (s == drive_monitor_pkg::st_op_enabled)
        || (s == drive_monitor_pkg::st_quick_stop) || (s == drive_monitor_pkg::st_fault_react);
  endfunction

  // Millisecond tick; a parameter so simulation can shrink it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_count <= 32'h0000_0000;
      ms_tick    <= 1'b0;
    end else if (tick_count >= TICK_CYCLES - 1) begin
      tick_count <= 32'h0000_0000;
      ms_tick    <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      ms_tick    <= 1'b0;
    end
  end

  // Window arithmetic; 33 bits so no wrap at the signed extremes
  always_comb begin
    lag_error   = {measured_pos[31], measured_pos} - {commanded_pos[31], commanded_pos};
    lag_mag     = lag_error[32] ? (33'd0 - lag_error) : lag_error;
    lag_outside = lag_mag > {1'b0, lag_tolerance};
    goal_error  = {measured_pos[31], measured_pos} - {goal_pos[31], goal_pos};
    goal_mag    = goal_error[32] ? (33'd0 - goal_error) : goal_error;
    arr_inside  = goal_mag <= {1'b0, arrival_tolerance};
  end

  // Lag grace timer; fault bit follows the current excursion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lag_count <= 16'h0000;
      lag_fault <= 1'b0;
    end else if (!lag_outside) begin
      lag_count <= 16'h0000;
      lag_fault <= 1'b0;
    end else begin
      if (ms_tick && lag_count != 16'hFFFF) begin
        lag_count <= lag_count + 16'h0001;
      end
      if (lag_count >= lag_grace_period) begin
        lag_fault <= 1'b1;
      end
    end
  end

  // Dwell timer; leaving the window drops the flag at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dwell_count <= 16'h0000;
      arrival     <= 1'b0;
    end else if (!arr_inside) begin
      dwell_count <= 16'h0000;
      arrival     <= 1'b0;
    end else begin
      if (ms_tick && dwell_count != 16'hFFFF) begin
        dwell_count <= dwell_count + 16'h0001;
      end
      if (dwell_count >= arrival_dwell) begin
        arrival <= 1'b1;
      end
    end
  end

  assign fault_reset_edge = command_word[`CMD_FAULT_RESET] & ~prev_fault_reset;

  // Power-stage transitions; alarm outranks any command except a fault reset in the fault state
  always_comb begin
    next_state = state;
    case (state)
      drive_monitor_pkg::st_not_ready: begin
        if (self_test_done) next_state = drive_monitor_pkg::st_sw_disabled;
      end
      drive_monitor_pkg::st_sw_disabled: begin
        if (is_shutdown(command_word)) next_state = drive_monitor_pkg::st_ready;
      end
      drive_monitor_pkg::st_ready: begin
        if (!command_word[`CMD_ENABLE_VOLTAGE] || is_quick_stop(command_word)) begin
          next_state = drive_monitor_pkg::st_sw_disabled;
        end else if (is_switch_on(command_word) || is_enable_op(command_word)) begin
          next_state = drive_monitor_pkg::st_switched_on;
        end
      end
      drive_monitor_pkg::st_switched_on: begin
        if (!command_word[`CMD_ENABLE_VOLTAGE] || is_quick_stop(command_word)) begin
          next_state = drive_monitor_pkg::st_sw_disabled;
        end else if (is_shutdown(command_word)) begin
          next_state = drive_monitor_pkg::st_ready;
        end else if (is_enable_op(command_word)) begin
          next_state = drive_monitor_pkg::st_op_enabled;
        end
      end
      drive_monitor_pkg::st_op_enabled: begin
        if (!command_word[`CMD_ENABLE_VOLTAGE]) begin
          next_state = drive_monitor_pkg::st_sw_disabled;
        end else if (is_quick_stop(command_word)) begin
          next_state = drive_monitor_pkg::st_quick_stop;
        end else if (is_shutdown(command_word)) begin
          next_state = drive_monitor_pkg::st_ready;
        end else if (is_switch_on(command_word)) begin
          next_state = drive_monitor_pkg::st_switched_on;
        end
      end
      drive_monitor_pkg::st_quick_stop: begin
        if (motor_stopped || !command_word[`CMD_ENABLE_VOLTAGE]) begin
          next_state = drive_monitor_pkg::st_sw_disabled;
        end
      end
      drive_monitor_pkg::st_fault_react: begin
        if (motor_stopped) next_state = drive_monitor_pkg::st_fault;
      end
      drive_monitor_pkg::st_fault: begin
        if (fault_reset_edge) next_state = drive_monitor_pkg::st_sw_disabled;
      end
      default: next_state = drive_monitor_pkg::st_not_ready;
    endcase
    if (alarm && state != drive_monitor_pkg::st_fault
        && state != drive_monitor_pkg::st_fault_react) begin
      next_state = drive_monitor_pkg::st_fault_react;
    end
  end

  // State and power outputs registered together so they never disagree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= drive_monitor_pkg::st_not_ready;
      main_power_on <= 1'b0;
      motor_excited <= 1'b0;
    end else begin
      state         <= next_state;
      main_power_on <= power_of(next_state);
      motor_excited <= (next_state == drive_monitor_pkg::st_op_enabled)
                    || (next_state == drive_monitor_pkg::st_quick_stop)
                    || (next_state == drive_monitor_pkg::st_fault_react);
    end
  end

  // State report word, refreshed every cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_report <= 16'h0000;
      halt_request <= 1'b0;
    end else begin
      state_report <= 16'h0000;
      case (state)
        drive_monitor_pkg::st_sw_disabled: state_report[`RPT_SW_ON_DISABLED] <= 1'b1;
        drive_monitor_pkg::st_ready: begin
          state_report[`RPT_QUICK_STOP] <= 1'b1;
          state_report[`RPT_READY]      <= 1'b1;
        end
        drive_monitor_pkg::st_switched_on: begin
          state_report[`RPT_QUICK_STOP]  <= 1'b1;
          state_report[`RPT_SWITCHED_ON:`RPT_READY] <= 2'b11;
        end
        drive_monitor_pkg::st_op_enabled: begin
          state_report[`RPT_QUICK_STOP] <= 1'b1;
          state_report[`RPT_OP_ENABLED:`RPT_READY] <= 3'b111;
        end
        drive_monitor_pkg::st_quick_stop: state_report[`RPT_OP_ENABLED:`RPT_READY] <= 3'b111;
        drive_monitor_pkg::st_fault_react: state_report[`RPT_FAULT:`RPT_READY] <= 4'b1111;
        drive_monitor_pkg::st_fault: state_report[`RPT_FAULT] <= 1'b1;
        default: state_report[`RPT_READY] <= 1'b0;
      endcase
      state_report[`RPT_VOLTAGE]   <= main_power_on;
      state_report[`RPT_WARNING]   <= alarm;
      state_report[`RPT_REMOTE]    <= state != drive_monitor_pkg::st_not_ready;
      // Gated by the live window test so the word drops with the flag, not a cycle later
      state_report[`RPT_ARRIVED]   <= arrival && arr_inside;
      state_report[`RPT_LAG_FAULT] <= lag_fault;
      halt_request <= command_word[`CMD_HALT];
    end
  end

  // Object writes; refused while self-test runs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      command_word             <= `RST_COMMAND_WORD;
      rapid_halt_behaviour     <= `RST_OPTION_CODE;
      power_down_behaviour     <= `RST_OPTION_CODE;
      run_stop_behaviour       <= `RST_OPTION_CODE;
      pause_behaviour          <= `RST_OPTION_CODE;
      error_response_behaviour <= `RST_OPTION_CODE;
      lag_tolerance            <= `RST_LAG_TOLERANCE;
      lag_grace_period         <= `RST_LAG_GRACE;
      arrival_tolerance        <= `RST_ARRIVAL_TOL;
      arrival_dwell            <= `RST_ARRIVAL_DWELL;
      prev_fault_reset         <= 1'b0;
    end else begin
      prev_fault_reset <= command_word[`CMD_FAULT_RESET];
      if (od_valid && od_write && state != drive_monitor_pkg::st_not_ready) begin
        if (od_index == `IDX_COMMAND_WORD) begin
          command_word <= od_wdata[15:0];
        end else if (od_index == `IDX_RAPID_HALT) begin
          rapid_halt_behaviour <= od_wdata[15:0];
        end else if (od_index == `IDX_POWER_DOWN) begin
          power_down_behaviour <= od_wdata[15:0];
        end else if (od_index == `IDX_RUN_STOP) begin
          run_stop_behaviour <= od_wdata[15:0];
        end else if (od_index == `IDX_PAUSE) begin
          pause_behaviour <= od_wdata[15:0];
        end else if (od_index == `IDX_ERROR_RESPONSE) begin
          error_response_behaviour <= od_wdata[15:0];
        end else if (od_index == `IDX_LAG_TOLERANCE) begin
          if (od_wdata <= `LAG_TOLERANCE_MAX) lag_tolerance <= od_wdata;
        end else if (od_index == `IDX_LAG_GRACE) begin
          lag_grace_period <= od_wdata[15:0];
        end else if (od_index == `IDX_ARRIVAL_TOL) begin
          arrival_tolerance <= od_wdata;
        end else if (od_index == `IDX_ARRIVAL_DWELL) begin
          arrival_dwell <= od_wdata[15:0];
        end
      end
    end
  end

  // Object reads and access answer, one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      od_ready <= 1'b0;
      od_error <= 1'b0;
      od_rdata <= 32'h0000_0000;
    end else begin
      od_ready <= od_valid;
      od_error <= 1'b0;
      od_rdata <= 32'h0000_0000;
      if (od_valid) begin
        if (state == drive_monitor_pkg::st_not_ready) begin
          od_error <= 1'b1;
        end else if (od_index == `IDX_COMMAND_WORD) begin
          od_rdata <= {16'h0000, command_word};
        end else if (od_index == `IDX_STATE_REPORT) begin
          od_rdata <= {16'h0000, state_report};
          od_error <= od_write;
        end else if (od_index == `IDX_RAPID_HALT) begin
          od_rdata <= {16'h0000, rapid_halt_behaviour};
        end else if (od_index == `IDX_POWER_DOWN) begin
          od_rdata <= {16'h0000, power_down_behaviour};
        end else if (od_index == `IDX_RUN_STOP) begin
          od_rdata <= {16'h0000, run_stop_behaviour};
        end else if (od_index == `IDX_PAUSE) begin
          od_rdata <= {16'h0000, pause_behaviour};
        end else if (od_index == `IDX_ERROR_RESPONSE) begin
          od_rdata <= {16'h0000, error_response_behaviour};
        end else if (od_index == `IDX_COMMANDED_LOC) begin
          od_rdata <= commanded_pos;
          od_error <= od_write;
        end else if (od_index == `IDX_MEASURED_RAW) begin
          od_rdata <= measured_raw_pos;
          od_error <= od_write;
        end else if (od_index == `IDX_MEASURED_LOC) begin
          od_rdata <= measured_pos;
          od_error <= od_write;
        end else if (od_index == `IDX_LAG_TOLERANCE) begin
          od_rdata <= lag_tolerance;
          od_error <= od_write && (od_wdata > `LAG_TOLERANCE_MAX);
        end else if (od_index == `IDX_LAG_GRACE) begin
          od_rdata <= {16'h0000, lag_grace_period};
        end else if (od_index == `IDX_ARRIVAL_TOL) begin
          od_rdata <= arrival_tolerance;
        end else if (od_index == `IDX_ARRIVAL_DWELL) begin
          od_rdata <= {16'h0000, arrival_dwell};
        end else if (od_index == `IDX_LOOP_OUTPUT) begin
          od_rdata <= loop_effort;
          od_error <= od_write;
        end else begin
          od_error <= 1'b1;
        end
      end
    end
  end

  // Checks
  property p_lag_set;
    @(posedge clk) disable iff (sys_rst)
      lag_outside && (lag_count >= lag_grace_period) |=> lag_fault;
  endproperty
  a_lag_set: assert property (p_lag_set) else $error("lag fault not raised after grace");

  property p_lag_cause;
    @(posedge clk) disable iff (sys_rst)
      $rose(lag_fault) |-> $past(lag_mag > {1'b0, lag_tolerance});
  endproperty
  a_lag_cause: assert property (p_lag_cause) else $error("lag fault without excursion");

  property p_arr_clear;
    @(posedge clk) disable iff (sys_rst)
      !arr_inside |=> !arrival;
  endproperty
  a_arr_clear: assert property (p_arr_clear) else $error("arrival not cleared at once");

  property p_arr_set;
    @(posedge clk) disable iff (sys_rst)
      $rose(arrival) |-> $past(arr_inside) && $past(dwell_count >= arrival_dwell);
  endproperty
  a_arr_set: assert property (p_arr_set) else $error("arrival set before dwell");

  property p_tol_range;
    @(posedge clk) disable iff (sys_rst)
      !lag_tolerance[31];
  endproperty
  a_tol_range: assert property (p_tol_range) else $error("lag tolerance out of range");

  property p_no_cmd_in_test;
    @(posedge clk) disable iff (sys_rst)
      od_valid && state == drive_monitor_pkg::st_not_ready |=> od_ready && od_error
        && $stable(command_word);
  endproperty
  a_no_cmd_in_test: assert property (p_no_cmd_in_test) else $error("access taken in self-test");

  sequence s_enter_run;
    (state != drive_monitor_pkg::st_op_enabled) ##1 (state == drive_monitor_pkg::st_op_enabled);
  endsequence
  property p_run_path;
    @(posedge clk) disable iff (sys_rst)
      s_enter_run |-> $past(state) == drive_monitor_pkg::st_switched_on;
  endproperty
  a_run_path: assert property (p_run_path) else $error("running entered out of order");

  property p_power_off;
    @(posedge clk) disable iff (sys_rst)
      (state == drive_monitor_pkg::st_fault || state == drive_monitor_pkg::st_sw_disabled
       || state == drive_monitor_pkg::st_ready) |-> !main_power_on;
  endproperty
  a_power_off: assert property (p_power_off) else $error("main power on while disabled");

  property p_alarm;
    @(posedge clk) disable iff (sys_rst)
      alarm && state != drive_monitor_pkg::st_fault |=>
        state == drive_monitor_pkg::st_fault_react || state == drive_monitor_pkg::st_fault;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not enter fault handling");

  property p_run_power;
    @(posedge clk) disable iff (sys_rst)
      state == drive_monitor_pkg::st_op_enabled |-> main_power_on && motor_excited;
  endproperty
  a_run_power: assert property (p_run_power) else $error("running without power");

endmodule
`default_nettype wire

// File: test/master_model.sv
// Fieldbus master model that drives the drive object port
`timescale 1ns/10ps
`default_nettype none
`include "drive_monitor_params.svh"
module master_model (
  // Clock
  input  wire logic        clk,
  // Object port
  output logic             od_valid,
  output logic             od_write,
  output logic      [15:0] od_index,
  output logic      [31:0] od_wdata,
  input  wire logic        od_ready,
  input  wire logic        od_error,
  input  wire logic [31:0] od_rdata
);
  // Idle port at time zero
  initial begin
    od_valid = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_wdata = 32'h0000_0000;
  end
  // One access, pulsed for a cycle; a missing answer counts as refused
  task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                        output logic err, output logic [31:0] q);
    @(negedge clk);
    od_valid = 1'b1;
    od_write = wr;
    od_index = idx;
    od_wdata = d;
    @(negedge clk);
    od_valid = 1'b0;
    od_wdata = ~d; // Released data must not look valid
    err = od_error | ~od_ready;
    q = od_rdata;
  endtask
  // State commands as command word values
  task automatic command(input int k);
    logic        e;
    logic [31:0] r;
    logic [31:0] w;
    case (k)
      0: w = 32'h0000_0006;
      1: w = 32'h0000_0007;
      2: w = 32'h0000_000F;
      3: w = 32'h0000_0000;
      4: w = 32'h0000_0002;
      default: w = 32'h0000_0080;
    endcase
    access(1'b1, `IDX_COMMAND_WORD, w, e, r);
  endtask
endmodule
`default_nettype wire

// File: test/test_drive_monitor.sv
// Self-checking bench of the drive monitor
`timescale 1ns/10ps
`default_nettype none
`include "drive_monitor_params.svh"
module test_drive_monitor;
  logic        clk, sys_rst, self_test_done, alarm, motor_stopped, od_valid, od_write;
  logic        od_ready, od_error, main_power_on, motor_excited, halt_request, lag_fault;
  logic        arrival, err;
  logic [15:0] od_index, state_report;
  logic [31:0] od_wdata, od_rdata, commanded_pos, measured_pos, measured_raw_pos;
  logic [31:0] goal_pos, loop_effort, q, seed, tol;
  logic [15:0] ri[5] = '{`IDX_COMMAND_WORD, `IDX_LAG_TOLERANCE, `IDX_LAG_GRACE,
                         `IDX_ARRIVAL_TOL, `IDX_ARRIVAL_DWELL};
  logic [31:0] rv[5] = '{32'h0000_0000, 32'h0000_7530, 32'h0000_00C8, 32'h0000_000A,
                         32'h0000_0032};
  int          miscompares, comparisons;
  // Short tick keeps millisecond counts fast
  drive_monitor #(.TICK_CYCLES(4)) drive_monitor_i (.clk, .sys_rst, .od_valid, .od_write,
    .od_index, .od_wdata, .od_ready, .od_error, .od_rdata, .commanded_pos, .measured_pos,
    .measured_raw_pos, .goal_pos, .loop_effort, .self_test_done, .alarm, .motor_stopped,
    .main_power_on, .motor_excited, .halt_request, .lag_fault, .arrival, .state_report);
  master_model master_model_i (.clk, .od_valid, .od_write, .od_index, .od_wdata,
    .od_ready, .od_error, .od_rdata);
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Report state bits 6, 5 and 3..0: idle, ready, on, running, reaction, fault
  function automatic logic [15:0] state_code(input int k);
    logic [15:0] c[6] = '{16'h0040, 16'h0021, 16'h0023, 16'h0027, 16'h000F, 16'h0008};
    return c[k];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic acc(input logic wr, input logic [15:0] i, input logic [31:0] d);
    master_model_i.access(wr, i, d, err, q);
  endtask
  // Idle to running, checking each stop on the way
  task automatic walk();
    for (int k = 0; k < 3; k++) begin
      master_model_i.command(k);
      step(3);
      chk("walk report", state_code(k + 1), state_report & 16'h006F);
      chk("walk power", k > 0, main_power_on);
    end
    chk("running excited", 1, motor_excited);
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {clk, self_test_done, alarm, motor_stopped, commanded_pos, measured_pos} = '0;
    sys_rst = 1'b1;
    seed = 32'h20b2;
    goal_pos = 32'h0000_1000;
    measured_raw_pos = lfsr(seed);
    loop_effort = ~measured_raw_pos;
    step(12);
    sys_rst = 1'b0;
    acc(0, `IDX_LAG_TOLERANCE, 0);
    chk("early access", 1, err);
    self_test_done = 1'b1;
    step(3);
    chk("idle report", state_code(0), state_report & 16'h006F);
    chk("idle power", 0, main_power_on);
    foreach (ri[i]) begin
      acc(0, ri[i], 0);
      chk("reset value", rv[i], q);
    end
    acc(0, `IDX_MEASURED_RAW, 0);
    chk("raw readback", measured_raw_pos, q);
    acc(0, `IDX_LOOP_OUTPUT, 0);
    chk("effort readback", loop_effort, q);
    acc(1, `IDX_LAG_TOLERANCE, 32'h8000_0000);
    chk("tolerance limit", 1, err);
    acc(1, `IDX_STATE_REPORT, 0);
    chk("report write", 1, err);
    $display("test registers done");
    walk();
    // Lag band with a random tolerance, lower edge first
    seed = lfsr(lfsr(seed));
    tol = {24'h00_0000, seed[7:0]} + 32'd20;
    acc(1, `IDX_LAG_TOLERANCE, tol);
    acc(1, `IDX_LAG_GRACE, 32'd3);
    commanded_pos = seed;
    measured_pos = seed - tol;
    step(40);
    chk("lag on edge", 0, lag_fault);
    measured_pos = seed + tol + 32'd1;
    step(6);
    chk("lag in grace", 0, lag_fault);
    step(14);
    chk("lag fault", 1, state_report[13]);
    chk("lag port", 1, lag_fault);
    $display("test lag done");
    acc(1, `IDX_ARRIVAL_DWELL, 32'd2);
    measured_pos = goal_pos - 32'd10;
    step(3);
    chk("arrival early", 0, arrival);
    step(10);
    chk("arrival set", 1, state_report[10]);
    measured_pos = goal_pos + 32'd11;
    step(1);
    chk("arrival clear", 0, arrival);
    chk("arrival report clear", 0, state_report[10]);
    $display("test arrival done");
    alarm = 1'b1;
    step(3);
    chk("reaction", state_code(4), state_report & 16'h006F);
    chk("reaction power", 1, main_power_on);
    motor_stopped = 1'b1;
    step(3);
    chk("fault", state_code(5), state_report & 16'h006F);
    chk("fault power", 0, main_power_on);
    {alarm, motor_stopped} = 2'b00;
    master_model_i.command(5);
    step(3);
    chk("fault reset", state_code(0), state_report & 16'h006F);
    $display("test fault done");
    walk();
    master_model_i.command(3);
    step(3);
    chk("voltage off", 0, main_power_on);
    master_model_i.command(0);
    master_model_i.command(4);
    step(3);
    chk("quick stop", state_code(0), state_report & 16'h006F);
    // Quick stop from running must pass through its own state
    walk();
    master_model_i.command(4);
    step(3);
    chk("quick stop active", 16'h0007, state_report & 16'h006F);
    chk("quick stop excited", 1, motor_excited);
    motor_stopped = 1'b1;
    step(3);
    chk("quick stop ended", state_code(0), state_report & 16'h006F);
    motor_stopped = 1'b0;
    acc(1, `IDX_COMMAND_WORD, 32'h0000_0100);
    step(2);
    chk("halt request", 1, halt_request);
    $display("test commands done");
    complete_run();
  end
endmodule
`default_nettype wire
